// ### hw/ahm_bus_master.v
`timescale 1ns/1ps
`include "ahm_defines.vh"

module ahm_bus_master (
    input  wire        clk,
    input  wire        nrst,
    input  wire        bus_edge_enable,
    input  wire        debug_tick_enable,
    input  wire        hgrant,
    input  wire        hready,
    input  wire [1:0]  hresp,
    input  wire [31:0] hrdata,
    output reg         hbusreq,
    output reg         hlock,
    output reg  [31:0] haddr,
    output reg  [1:0]  htrans,
    output reg         hwrite,
    output reg  [2:0]  hsize,
    output reg  [2:0]  hburst,
    output reg  [3:0]  hprot,
    output reg  [31:0] hwdata,
    input  wire        user_req,
    input  wire        user_write,
    input  wire [31:0] user_addr,
    input  wire [1:0]  user_size,
    input  wire [1:0]  user_kind,
    input  wire [3:0]  user_beats,
    input  wire        user_data_access,
    input  wire        user_supervisor,
    input  wire        user_bufferable,
    input  wire        user_cacheable,
    input  wire        atomic_swap_instruction,
    input  wire [31:0] user_wdata,
    output reg         user_wdata_take,
    output reg         user_rdata_valid,
    output reg  [31:0] user_rdata,
    output reg         user_done,
    output reg         user_error,
    output reg         stall_clock_enable_out,
    output reg  [7:0]  debug_beat_count
);

    // Number of beats a request moves; an open increment of zero beats counts as one.
    function [3:0] ahm_beats;
        input [1:0] kind;
        input [3:0] beats;
        begin
            case (kind)
                `AHM_KIND_INCR4: ahm_beats = `AHM_BEATS_INCR4;
                `AHM_KIND_INCR8: ahm_beats = `AHM_BEATS_INCR8;
                `AHM_KIND_INCR:  ahm_beats = (beats == 4'h0) ? 4'h1 : beats;
                default:         ahm_beats = 4'h1;
            endcase
        end
    endfunction

    // Burst code for a request kind; only incrementing forms exist.
    function [2:0] ahm_burst;
        input [1:0] kind;
        begin
            case (kind)
                `AHM_KIND_INCR4: ahm_burst = `AHM_BURST_INCR4;
                `AHM_KIND_INCR8: ahm_burst = `AHM_BURST_INCR8;
                `AHM_KIND_INCR:  ahm_burst = `AHM_BURST_INCR;
                default:         ahm_burst = `AHM_BURST_SINGLE;
            endcase
        end
    endfunction

    // Byte step between beats for a transfer size.
    function [31:0] ahm_step;
        input [1:0] size;
        begin
            case (size)
                `AHM_SIZE_BYTE: ahm_step = 32'h00000001;
                `AHM_SIZE_HALF: ahm_step = 32'h00000002;
                default:        ahm_step = 32'h00000004;
            endcase
        end
    endfunction

    reg        busy;
    reg        req_served;
    reg        cmd_write;
    reg [1:0]  cmd_size;
    reg [1:0]  cmd_kind;
    reg [3:0]  cmd_beats;
    reg        cmd_lock;
    reg [31:0] cur_addr;
    reg [3:0]  addr_left;
    reg [3:0]  data_left;
    reg        dphase;
    reg        dwrite;
    reg [31:0] daddr;
    reg [3:0]  dbg_backlog;
    reg        beat_done;

    wire       resp_bad   = dphase && (hresp != `AHM_RESP_OKAY);
    wire       issue      = busy && hgrant && (addr_left != 4'h0) && !resp_bad;
    wire       seq_next   = (htrans != `AHM_TRANS_IDLE) && (addr_left != cmd_beats);
    wire       keep_lock  = cmd_lock && !cmd_write;
    wire [1:0] size_clamp = (user_size == 2'h3) ? `AHM_SIZE_WORD : user_size;
    wire       dbg_take   = debug_tick_enable && (dbg_backlog != 4'h0);

    // Debug beat counter: completed beats queue in a backlog and drain only on debug ticks.
    always @(posedge clk) begin
        if (!nrst) begin
            dbg_backlog      <= 4'h0;
            debug_beat_count <= 8'h00;
        end else begin
            if (dbg_take) begin
                debug_beat_count <= debug_beat_count + 8'h01;
            end
            if (beat_done && !dbg_take && dbg_backlog != `AHM_DBG_MAX) begin
                dbg_backlog <= dbg_backlog + 4'h1;
            end else if (!beat_done && dbg_take) begin
                dbg_backlog <= dbg_backlog - 4'h1;
            end
        end
    end

    // Everything is registered on the single rising edge, so stretched phases change nothing.
    always @(posedge clk) begin
        if (!nrst) begin
            hbusreq                <= 1'b0;
            hlock                  <= 1'b0;
            haddr                  <= 32'h00000000;
            htrans                 <= `AHM_TRANS_IDLE;
            hwrite                 <= 1'b0;
            hsize                  <= 3'h0;
            hburst                 <= `AHM_BURST_SINGLE;
            hprot                  <= 4'h0;
            hwdata                 <= 32'h00000000;
            user_wdata_take        <= 1'b0;
            user_rdata_valid       <= 1'b0;
            user_rdata             <= 32'h00000000;
            user_done              <= 1'b0;
            user_error             <= 1'b0;
            stall_clock_enable_out <= 1'b1;
            busy                   <= 1'b0;
            req_served             <= 1'b0;
            cmd_write              <= 1'b0;
            cmd_size               <= 2'h0;
            cmd_kind               <= 2'h0;
            cmd_beats              <= 4'h0;
            cmd_lock               <= 1'b0;
            cur_addr               <= 32'h00000000;
            addr_left              <= 4'h0;
            data_left              <= 4'h0;
            dphase                 <= 1'b0;
            dwrite                 <= 1'b0;
            daddr                  <= 32'h00000000;
            beat_done              <= 1'b0;
        end else begin
            user_wdata_take  <= 1'b0;
            user_rdata_valid <= 1'b0;
            user_done        <= 1'b0;
            user_error       <= 1'b0;
            beat_done        <= 1'b0;
            if (!user_req) begin
                req_served <= 1'b0;
            end
            // Off bus edges nothing on the bus side moves and no bus input is looked at.
            if (bus_edge_enable) begin
                if (hready) begin
                    if (dphase) begin
                        case (hresp)
                            `AHM_RESP_OKAY: begin
                                beat_done <= 1'b1;
                                if (!dwrite) begin
                                    user_rdata       <= hrdata;
                                    user_rdata_valid <= 1'b1;
                                end
                                data_left <= data_left - 4'h1;
                                if (data_left == 4'h1) begin
                                    busy                   <= 1'b0;
                                    user_done              <= 1'b1;
                                    req_served             <= 1'b1;
                                    stall_clock_enable_out <= 1'b1;
                                    hbusreq                <= keep_lock;
                                    hlock                  <= keep_lock;
                                end
                            end
                            `AHM_RESP_ERROR: begin
                                busy                   <= 1'b0;
                                user_done              <= 1'b1;
                                user_error             <= 1'b1;
                                req_served             <= 1'b1;
                                stall_clock_enable_out <= 1'b1;
                                hbusreq                <= 1'b0;
                                hlock                  <= 1'b0;
                            end
                            default: begin
                                // Retry and split rewind to the refused beat and reissue it.
                                cur_addr  <= daddr;
                                addr_left <= data_left;
                            end
                        endcase
                    end
                    dphase <= (htrans != `AHM_TRANS_IDLE);
                    dwrite <= hwrite;
                    daddr  <= haddr;
                    if (htrans != `AHM_TRANS_IDLE && hwrite) begin
                        hwdata          <= user_wdata;
                        user_wdata_take <= 1'b1;
                    end
                    if (issue) begin
                        haddr     <= cur_addr;
                        cur_addr  <= cur_addr + ahm_step(cmd_size);
                        addr_left <= addr_left - 4'h1;
                        if (seq_next) begin
                            htrans <= `AHM_TRANS_SEQ;
                        end else begin
                            htrans <= `AHM_TRANS_NONSEQ;
                            // A burst broken by lost grant or retry resumes as an open increment.
                            if (addr_left == cmd_beats) begin
                                hburst <= ahm_burst(cmd_kind);
                            end else begin
                                hburst <= `AHM_BURST_INCR;
                            end
                        end
                    end else begin
                        htrans <= `AHM_TRANS_IDLE;
                    end
                end else if (resp_bad) begin
                    // First cycle of a two-cycle response cancels the pending address.
                    htrans <= `AHM_TRANS_IDLE;
                end
                if (!busy && user_req && !req_served) begin
                    busy                   <= 1'b1;
                    stall_clock_enable_out <= 1'b0;
                    hbusreq                <= 1'b1;
                    hlock                  <= atomic_swap_instruction;
                    cmd_write              <= user_write;
                    cmd_size               <= size_clamp;
                    cmd_kind               <= user_kind;
                    cmd_beats              <= ahm_beats(user_kind, user_beats);
                    cmd_lock               <= atomic_swap_instruction;
                    cur_addr               <= user_addr;
                    addr_left              <= ahm_beats(user_kind, user_beats);
                    data_left              <= ahm_beats(user_kind, user_beats);
                    hwrite                 <= user_write;
                    hsize                  <= {1'b0, size_clamp};
                    hprot[`AHM_PROT_DATA]  <= user_data_access;
                    hprot[`AHM_PROT_SUPER] <= user_supervisor;
                    hprot[`AHM_PROT_BUFF]  <= user_bufferable;
                    hprot[`AHM_PROT_CACHE] <= user_cacheable;
                end else if (!busy && hlock && !atomic_swap_instruction) begin
                    // A swap abandoned after its read must not hold the bus forever.
                    hlock   <= 1'b0;
                    hbusreq <= 1'b0;
                end
            end
        end
    end

endmodule // ahm_bus_master

// ### common/ahm_defines.vh
`ifndef AHM_DEFINES_VH
`define AHM_DEFINES_VH

`define AHM_TRANS_IDLE    2'h0
`define AHM_TRANS_NONSEQ  2'h1
`define AHM_TRANS_SEQ     2'h2

`define AHM_BURST_SINGLE  3'h0
`define AHM_BURST_INCR    3'h1
`define AHM_BURST_INCR4   3'h3
`define AHM_BURST_INCR8   3'h5

`define AHM_RESP_OKAY     2'h0
`define AHM_RESP_ERROR    2'h1
`define AHM_RESP_RETRY    2'h2
`define AHM_RESP_SPLIT    2'h3

`define AHM_SIZE_BYTE     2'h0
`define AHM_SIZE_HALF     2'h1
`define AHM_SIZE_WORD     2'h2

`define AHM_KIND_SINGLE   2'h0
`define AHM_KIND_INCR4    2'h1
`define AHM_KIND_INCR8    2'h2
`define AHM_KIND_INCR     2'h3

`define AHM_BEATS_INCR4   4'h4
`define AHM_BEATS_INCR8   4'h8

`define AHM_PROT_DATA     0
`define AHM_PROT_SUPER    1
`define AHM_PROT_BUFF     2
`define AHM_PROT_CACHE    3

`define AHM_DBG_MAX       4'hF

`endif

// ### bench/ahm_slave_model.sv
`timescale 1ns/1ps
module ahm_slave_model (
    input  wire        clk,
    input  wire        nrst,
    input  wire        bus_edge_enable,
    input  wire        hbusreq,
    input  wire        hlock,
    input  wire [1:0]  htrans,
    input  wire [31:0] haddr,
    input  wire        hwrite,
    input  wire        gnt_ok,
    input  wire        fail,
    input  wire [1:0]  waits,
    output reg         hgrant,
    output reg         hready,
    output reg  [1:0]  hresp,
    output wire [31:0] hrdata
);
    reg        dph;
    reg        dwr;
    reg [31:0] dad;
    reg [31:0] junk;
    reg [1:0]  cnt;
    // Idle read lines toggle every cycle so that stale data cannot pass.
    assign hrdata = (dph && !dwr) ? {dad[15:0], ~dad[15:0]} : junk;
    always @(posedge clk) begin
        junk <= nrst ? ~junk : 32'h0F0F0F0F;
        if (!nrst) begin
            hgrant <= 1'b0;
            hready <= 1'b1;
            hresp  <= 2'h0;
            dph    <= 1'b0;
            cnt    <= 2'h0;
        end else if (bus_edge_enable) begin
            hgrant <= (hbusreq | hlock) & gnt_ok;
            if (hready) begin
                dph    <= htrans != 2'h0;
                dwr    <= hwrite;
                dad    <= haddr;
                cnt    <= fail ? 2'h1 : waits;
                hresp  <= (htrans != 2'h0 && fail) ? 2'h1 : 2'h0;
                hready <= !(htrans != 2'h0 && (fail || waits != 2'h0));
            end else begin
                cnt    <= cnt - 2'h1;
                hready <= cnt == 2'h1;
            end
        end
    end
endmodule // ahm_slave_model

// ### bench/ahm_bus_master_assertions.sv
`timescale 1ns/1ps
`include "ahm_defines.vh"
module ahm_bus_master_assertions (
    input wire        clk,
    input wire        nrst,
    input wire        bus_edge_enable,
    input wire        hgrant,
    input wire        hready,
    input wire [1:0]  hresp,
    input wire        hbusreq,
    input wire        hlock,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire [2:0]  hsize,
    input wire [2:0]  hburst,
    input wire        atomic_swap_instruction,
    input wire        stall_clock_enable_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_issue;
        htrans == `AHM_TRANS_IDLE ##1 htrans == `AHM_TRANS_NONSEQ;
    endsequence
    property p_grant;
        s_issue |-> $past(hgrant && hready && bus_edge_enable);
    endproperty
    property p_hold;
        $past(!bus_edge_enable) && $past(nrst) |->
            $stable(htrans) && $stable(haddr) && $stable(hburst) && $stable(hbusreq);
    endproperty
    property p_wait;
        bus_edge_enable && !hready && hresp == `AHM_RESP_OKAY && htrans != `AHM_TRANS_IDLE
            |=> $stable(htrans) && $stable(haddr);
    endproperty
    property p_trans; htrans != 2'h3; endproperty
    property p_size; hsize[2] == 1'b0 && hsize != 3'h3; endproperty
    property p_burst; hburst inside {3'h0, 3'h1, 3'h3, 3'h5}; endproperty
    property p_busreq; htrans != `AHM_TRANS_IDLE |-> hbusreq; endproperty
    property p_stall; htrans != `AHM_TRANS_IDLE |-> !stall_clock_enable_out; endproperty
    property p_lock; $rose(hlock) |-> $past(atomic_swap_instruction); endproperty
    a_grant: assert property (p_grant)
        else $error("address phase without grant");
    a_hold: assert property (p_hold)
        else $error("bus output moved off a bus edge");
    a_wait: assert property (p_wait)
        else $error("transfer moved during wait");
    a_trans: assert property (p_trans)
        else $error("busy transfer type");
    a_size: assert property (p_size)
        else $error("bad size code");
    a_burst: assert property (p_burst)
        else $error("bad burst code");
    a_busreq: assert property (p_busreq)
        else $error("transfer without request");
    a_stall: assert property (p_stall)
        else $error("stall enable high during transfer");
    a_lock: assert property (p_lock)
        else $error("lock without swap");
endmodule // ahm_bus_master_assertions
bind ahm_bus_master ahm_bus_master_assertions ahm_bus_master_assertions_i (.*);

// ### bench/tb_ahm_bus_master.sv
`timescale 1ns/1ps
`include "ahm_defines.vh"
module tb_ahm_bus_master;
    logic        clk, nrst, bus_edge_enable, debug_tick_enable, hgrant, hready, hbusreq;
    logic        hlock, hwrite, user_req, user_write, user_data_access, user_supervisor;
    logic        user_bufferable, user_cacheable, atomic_swap_instruction, user_wdata_take;
    logic        user_rdata_valid, user_done, user_error, stall_clock_enable_out;
    logic        gnt_ok, fail, slow;
    logic [1:0]  hresp, htrans, user_size, user_kind, waits;
    logic [2:0]  hsize, hburst;
    logic [3:0]  hprot, user_beats;
    logic [7:0]  debug_beat_count, obeat;
    logic [31:0] hrdata, haddr, hwdata, user_addr, user_wdata, user_rdata, base, st;
    int          failures, checked, k, ab, wk;
    ahm_bus_master ahm_bus_master_i (.*);
    ahm_slave_model ahm_slave_model_i (.*);
    function automatic [31:0] wpat(input [31:0] a);
        wpat = a ^ 32'hA5C30F96;
    endfunction
    function automatic [31:0] nb(input [1:0] kd, input [3:0] b);
        nb = kd == 2'h0 ? 32'h1 : kd == 2'h1 ? 32'h4 : kd == 2'h2 ? 32'h8 : b == 4'h0 ? 32'h1 : b;
    endfunction
    function automatic [2:0] bexp(input [1:0] kd);
        bexp = kd == 2'h0 ? `AHM_BURST_SINGLE : kd == 2'h1 ? `AHM_BURST_INCR4 :
               kd == 2'h2 ? `AHM_BURST_INCR8 : `AHM_BURST_INCR;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
        checked++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task stop_test;
        if (failures == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [1:0] sz, kd, input logic [3:0] b, input logic e);
        int i;
        @(negedge clk);
        st = sz == 2'h3 ? 32'h4 : 32'h1 << sz;
        base = $urandom & ~(st - 32'h1);
        {k, ab, wk} = {32'h0, 32'h0, 32'h0};
        {user_write, user_size, user_kind, user_beats, fail, user_addr} = {w, sz, kd, b, e, base};
        {user_cacheable, user_bufferable, user_supervisor, user_data_access} = 4'($urandom);
        waits = 2'($urandom);
        gnt_ok = atomic_swap_instruction;
        user_req = 1'b1;
        repeat (3) @(negedge clk);
        gnt_ok = 1'b1;
        for (i = 0; i < 500 && user_done !== 1'b1; i++) @(negedge clk);
        chk(user_done, 1'b1, "user_done");
        chk(user_error, e, "user_error");
        @(negedge clk);
        user_req = 1'b0;
        chk(stall_clock_enable_out, 1'b1, "stall");
        if (!e) chk({k[15:0], ab[15:0]}, {w ? 16'h0 : 16'(nb(kd, b)), 16'(nb(kd, b))}, "beats");
    endtask
    always @(posedge clk) begin
        if (user_rdata_valid) begin
            chk(user_rdata, {base[15:0] + 16'(k * st), ~(base[15:0] + 16'(k * st))}, "rdata");
            k++;
        end
        if (nrst && bus_edge_enable && hready) begin
            if (htrans != `AHM_TRANS_IDLE) begin
                chk(haddr, base + ab * st, "haddr");
                chk({htrans, hwrite, hsize, hburst, hprot}, {ab == 0 ? `AHM_TRANS_NONSEQ :
                    `AHM_TRANS_SEQ, user_write, user_size == 2'h3 ? 3'h2 : {1'b0, user_size},
                    bexp(user_kind), user_cacheable, user_bufferable, user_supervisor,
                    user_data_access}, "ctrl");
                ab++;
            end
            if (ahm_slave_model_i.dph && ahm_slave_model_i.dwr)
                chk(hwdata, wpat(ahm_slave_model_i.dad), "hwdata");
            if (ahm_slave_model_i.dph && hresp == `AHM_RESP_OKAY) obeat++;
        end
    end
    always @(negedge clk) begin
        if (user_wdata_take) wk++;
        user_wdata <= wpat(base + wk * st);
        bus_edge_enable <= slow ? $urandom % 4 != 0 : 1'b1;
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #250000;
        failures++;
        stop_test;
    end
    initial begin
        {nrst, user_req, atomic_swap_instruction, slow, fail, gnt_ok, bus_edge_enable} = 7'h1;
        {user_write, user_size, user_kind, user_beats, waits, obeat, debug_tick_enable} = 20'h1;
        {user_data_access, user_supervisor, user_bufferable, user_cacheable} = 4'h0;
        {user_addr, user_wdata, base, st} = 128'h0;
        {failures, checked} = 64'h0;
        void'($urandom(92578));
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        chk({htrans, stall_clock_enable_out, hbusreq}, 4'h2, "reset");
        for (int i = 0; i < 8; i++) xfer(i[2], 2'(i), 2'(i), 4'h3, 1'b0);
        xfer(1'b0, 2'h2, 2'h1, 4'h0, 1'b1);
        atomic_swap_instruction = 1'b1;
        xfer(1'b0, 2'h2, 2'h0, 4'h0, 1'b0);
        chk(hlock, 1'b1, "hlock");
        xfer(1'b1, 2'h2, 2'h0, 4'h0, 1'b0);
        atomic_swap_instruction = 1'b0;
        repeat (20) @(negedge clk);
        chk(hlock, 1'b0, "hlock");
        chk(debug_beat_count, obeat, "debug");
        debug_tick_enable = 1'b0;
        xfer(1'b0, 2'h2, 2'h2, 4'h0, 1'b0);
        chk(debug_beat_count, obeat - 8'h8, "debug");
        debug_tick_enable = 1'b1;
        slow = 1'b1;
        for (int i = 0; i < 40; i++) xfer(1'($urandom), 2'($urandom), 2'($urandom), 4'($urandom), 1'b0);
        repeat (20) @(negedge clk);
        chk(debug_beat_count, obeat, "debug");
        stop_test;
    end
endmodule // tb_ahm_bus_master
